// >>> hw/drq_pkg.sv
package drq_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [7:0]  IDX_DRIVE_ADDR = 8'h4f;
  localparam logic [7:0]  IDX_REASON     = 8'h50;
  localparam logic [7:0]  IDX_ENABLE     = 8'h54;
  localparam logic [7:0]  IDX_ENDPOINT   = 8'h58;
  localparam logic [31:0] BA_DRIVE_ADDR  = {22'h000000, IDX_DRIVE_ADDR, 2'h0};
  localparam logic [31:0] BA_REASON      = {22'h000000, IDX_REASON, 2'h0};
  localparam logic [31:0] BA_ENABLE      = {22'h000000, IDX_ENABLE, 2'h0};
  localparam logic [31:0] BA_ENDPOINT    = {22'h000000, IDX_ENDPOINT, 2'h0};

  // reason / enable bit positions
  localparam int unsigned BIT_DRIVE_IRQ   = 9;
  localparam int unsigned BIT_COUNT_DONE  = 8;
  localparam int unsigned BIT_WR_EMPTY    = 7;
  localparam int unsigned BIT_WR_FULL     = 6;
  localparam int unsigned BIT_RD_EMPTY    = 5;
  localparam int unsigned BIT_RD_AVAIL    = 4;
  localparam int unsigned BIT_BUSY_DONE   = 3;
  localparam int unsigned BIT_TF_READBACK = 2;
  localparam int unsigned BIT_XFER_IRQ    = 1;
  localparam logic [15:0] REASON_MASK     = 16'h03fe;

  // endpoint register fields
  localparam int unsigned EP_DIR_BIT = 0;
  localparam int unsigned EP_IDX_LSB = 1;
  localparam int unsigned EP_IDX_MSB = 3;
  localparam logic [7:0]  EP_MASK    = 8'h0f;

  // reset values
  localparam logic [7:0]  RST_DRIVE_ADDR = 8'h00;
  localparam logic [15:0] RST_REASON     = 16'h0000;
  localparam logic [15:0] RST_ENABLE     = 16'h0000;
  localparam logic [7:0]  RST_ENDPOINT   = 8'h00;

  // drive-side select code of the drive-address task file
  localparam logic       TF_CS1_SEL  = 1'b0;
  localparam logic       TF_CS0_SEL  = 1'b1;
  localparam logic [2:0] TF_DA_SEL   = 3'h7;
  localparam logic       TF_CS_IDLE  = 1'b1;
  localparam logic [2:0] TF_DA_IDLE  = 3'h0;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HRESP_OKAY    = 2'h0;

  // levels reported by the dma engine and drive interface
  typedef struct packed {
    logic drive_intrq;
    logic wr_fifo_empty;
    logic wr_fifo_full;
    logic rd_fifo_empty;
    logic rd_fifo_avail;
    logic drive_bsy;
    logic poll_active;
    logic count_zero;
  } drq_level_s;

  // one-cycle events from the dma engine
  typedef struct packed {
    logic cmd_start;
    logic cmd_done;
    logic tf_readback_done;
    logic tf_push;
  } drq_pulse_s;

  // drive-side strobe of the drive-address task file
  typedef struct packed {
    logic       strobe;
    logic       cs1;
    logic       cs0;
    logic [2:0] da;
    logic [7:0] data;
  } drq_tf_s;

endpackage : drq_pkg

// >>> hw/drq_regs.sv
`timescale 1ns/10ps
// Function
// - drive address task file, 8-bit, reset zero
// - level flags (bits 9..4) refreshed at command completion
// - writing one clears flag, zero keeps
// - bit 9 set on drive interrupt
// - bit 8 on count zero, dma modes
// - bit 7 set when write FIFO empty
// - bit 6 set when write FIFO full
// - bit 5 set when read FIFO empty
// - bit 4 set when FIFO holds data
// - bit 3 set when busy polling ends
// - bit 2 set on task-file readback done
// - bit 1 needs count zero and interrupt
// - enable register, one bit per flag
// - enables cleared by reset
// - endpoint register selects dma FIFO
// - bits 3..1 select endpoint index
// - bit 0 selects transfer direction
// - all sources merged onto one interrupt
// - interrupt clears via reason flags or enables
module drq_regs
(
  // clock and reset
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // ahb-lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic [1:0]               hresp,
  output logic [31:0]              hrdata,
  // engine status
  input  wire drq_pkg::drq_level_s lvl,
  input  wire drq_pkg::drq_pulse_s evt,
  input  wire logic                ata_mode,
  input  wire logic                generic_slave_dma_mode,
  input  wire logic                master_dma_mode,
  // outputs to engine and drive
  output logic                     dma_irq,
  output logic [2:0]               dma_endpoint_index,
  output logic                     dma_direction_select,
  output logic [7:0]               drive_address,
  output drq_pkg::drq_tf_s         tf_out
);

  logic [7:0]       drive_addr_r;
  logic [15:0]      reason_r;
  logic [15:0]      reason_nxt;
  logic [15:0]      enable_r;
  logic [7:0]       endpoint_r;
  logic [31:0]      hrdata_r;
  logic             dp_wr_r;
  logic [31:0]      dp_addr_r;
  drq_pkg::drq_level_s lvl_r;
  logic             cnt_seen_r;
  logic             irq_seen_r;
  drq_pkg::drq_tf_s tf_r;

  // bus decode
  wire        addr_ok   = hsel & hready & (htrans == drq_pkg::HTRANS_NONSEQ);
  wire        rd_take   = addr_ok & ~hwrite;
  wire        wr_take   = addr_ok & hwrite;
  wire        hit_drv   = (haddr == drq_pkg::BA_DRIVE_ADDR);
  wire        hit_rsn   = (haddr == drq_pkg::BA_REASON);
  wire        hit_ena   = (haddr == drq_pkg::BA_ENABLE);
  wire        hit_ep    = (haddr == drq_pkg::BA_ENDPOINT);
  wire        wr_drv    = dp_wr_r & (dp_addr_r == drq_pkg::BA_DRIVE_ADDR);
  wire        wr_rsn    = dp_wr_r & (dp_addr_r == drq_pkg::BA_REASON);
  wire        wr_ena    = dp_wr_r & (dp_addr_r == drq_pkg::BA_ENABLE);
  wire        wr_ep     = dp_wr_r & (dp_addr_r == drq_pkg::BA_ENDPOINT);
  // unmapped reads return zero
  wire [31:0] rd_mux    = hit_drv ? {24'h000000, drive_addr_r} :
                          hit_rsn ? {16'h0000, reason_r} :
                          hit_ena ? {16'h0000, enable_r} :
                          hit_ep  ? {24'h000000, endpoint_r} : 32'h00000000;

  // event detection
  wire        dma_mode   = generic_slave_dma_mode | master_dma_mode;
  wire        intrq_rise = lvl.drive_intrq & ~lvl_r.drive_intrq;
  wire        cnt_rise   = lvl.count_zero & ~lvl_r.count_zero;
  wire        busy_end   = (lvl_r.poll_active | lvl_r.drive_bsy) &
                           ~lvl.poll_active & ~lvl.drive_bsy;
  wire        cnt_now    = cnt_seen_r | cnt_rise;
  wire        irq_now    = irq_seen_r | intrq_rise;
  wire        refresh    = evt.cmd_done;
  wire [15:0] w1c_vec    = wr_rsn ? hwdata[15:0] : 16'h0000;
  wire [15:0] set_vec;

  assign set_vec[15:10] = 6'h00;
  assign set_vec[drq_pkg::BIT_DRIVE_IRQ] = intrq_rise | (refresh & lvl.drive_intrq);
  assign set_vec[drq_pkg::BIT_COUNT_DONE] = dma_mode & (cnt_rise | (refresh & lvl.count_zero));
  assign set_vec[drq_pkg::BIT_WR_EMPTY] = (lvl.wr_fifo_empty & ~lvl_r.wr_fifo_empty) |
                                          (refresh & lvl.wr_fifo_empty);
  assign set_vec[drq_pkg::BIT_WR_FULL] = (lvl.wr_fifo_full & ~lvl_r.wr_fifo_full) |
                                         (refresh & lvl.wr_fifo_full);
  assign set_vec[drq_pkg::BIT_RD_EMPTY] = (lvl.rd_fifo_empty & ~lvl_r.rd_fifo_empty) |
                                          (refresh & lvl.rd_fifo_empty);
  assign set_vec[drq_pkg::BIT_RD_AVAIL] = (lvl.rd_fifo_avail & ~lvl_r.rd_fifo_avail) |
                                          (refresh & lvl.rd_fifo_avail);
  assign set_vec[drq_pkg::BIT_BUSY_DONE] = busy_end;
  assign set_vec[drq_pkg::BIT_TF_READBACK] = evt.tf_readback_done;
  // both conditions since command start, in either order
  assign set_vec[drq_pkg::BIT_XFER_IRQ] = cnt_now & irq_now & ~(cnt_seen_r & irq_seen_r);
  assign set_vec[0] = 1'b0;

  // set beats a same-cycle clear so no event is lost
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_flag
      assign reason_nxt[gi] = drq_pkg::REASON_MASK[gi] &
                              (set_vec[gi] | (reason_r[gi] & ~w1c_vec[gi]));
    end
  endgenerate

  // bus phase tracking; zero wait states
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_wr_r   <= 1'b0;
      dp_addr_r <= 32'h00000000;
      hrdata_r  <= 32'h00000000;
    end
    else
    begin
      dp_wr_r   <= wr_take;
      dp_addr_r <= wr_take ? haddr : dp_addr_r;
      hrdata_r  <= rd_take ? rd_mux : hrdata_r;
    end
  end

  // registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      drive_addr_r <= drq_pkg::RST_DRIVE_ADDR;
      reason_r     <= drq_pkg::RST_REASON;
      enable_r     <= drq_pkg::RST_ENABLE;
      endpoint_r   <= drq_pkg::RST_ENDPOINT;
    end
    else
    begin
      drive_addr_r <= wr_drv ? hwdata[7:0] : drive_addr_r;
      reason_r     <= reason_nxt;
      enable_r     <= wr_ena ? (hwdata[15:0] & drq_pkg::REASON_MASK) : enable_r;
      endpoint_r   <= wr_ep ? (hwdata[7:0] & drq_pkg::EP_MASK) : endpoint_r;
    end
  end

  // event history; cnt_seen_r and irq_seen_r cleared at each command start
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lvl_r      <= '0;
      cnt_seen_r <= 1'b0;
      irq_seen_r <= 1'b0;
    end
    else
    begin
      lvl_r      <= lvl;
      cnt_seen_r <= evt.cmd_start ? 1'b0 : cnt_now;
      irq_seen_r <= evt.cmd_start ? 1'b0 : irq_now;
    end
  end

  // drive-side strobe; suppressed in packet mode where the register is reserved
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tf_r.strobe <= 1'b0;
      tf_r.cs1    <= drq_pkg::TF_CS_IDLE;
      tf_r.cs0    <= drq_pkg::TF_CS_IDLE;
      tf_r.da     <= drq_pkg::TF_DA_IDLE;
      tf_r.data   <= 8'h00;
    end
    else if (evt.tf_push && ata_mode)
    begin
      tf_r.strobe <= 1'b1;
      tf_r.cs1    <= drq_pkg::TF_CS1_SEL;
      tf_r.cs0    <= drq_pkg::TF_CS0_SEL;
      tf_r.da     <= drq_pkg::TF_DA_SEL;
      tf_r.data   <= drive_addr_r;
    end
    else
    begin
      tf_r.strobe <= 1'b0;
      tf_r.cs1    <= drq_pkg::TF_CS_IDLE;
      tf_r.cs0    <= drq_pkg::TF_CS_IDLE;
      tf_r.da     <= drq_pkg::TF_DA_IDLE;
      tf_r.data   <= tf_r.data;
    end
  end

  assign hreadyout            = 1'b1;
  assign hresp                = drq_pkg::HRESP_OKAY;
  assign hrdata               = hrdata_r;
  // no direct clear path: falls only with the flags or their enables
  assign dma_irq              = |(reason_r & enable_r);
  assign dma_endpoint_index   = endpoint_r[drq_pkg::EP_IDX_MSB:drq_pkg::EP_IDX_LSB];
  assign dma_direction_select = endpoint_r[drq_pkg::EP_DIR_BIT];
  assign drive_address        = ata_mode ? drive_addr_r : 8'h00;
  assign tf_out               = tf_r;

  // checks
  a_irq_merge: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(dma_irq) |-> $past(wr_rsn || wr_ena))
    else $error("dma interrupt dropped without a flag or enable write");

  a_irq_masked: assert property (@(posedge hclk) disable iff (!hresetn)
    (enable_r == 16'h0000) |-> !dma_irq)
    else $error("dma interrupt raised with all enables clear");

  a_w1c_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_rsn && hwdata[drq_pkg::BIT_TF_READBACK] && !evt.tf_readback_done)
    |=> !reason_r[drq_pkg::BIT_TF_READBACK])
    else $error("reason flag not cleared by writing one");

  a_w0_keep: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_rsn && !hwdata[drq_pkg::BIT_BUSY_DONE] && reason_r[drq_pkg::BIT_BUSY_DONE])
    |=> reason_r[drq_pkg::BIT_BUSY_DONE])
    else $error("reason flag lost on writing zero");

  a_intrq_set: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(lvl.drive_intrq) |=> reason_r[drq_pkg::BIT_DRIVE_IRQ])
    else $error("drive interrupt flag not set");

  a_count_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(reason_r[drq_pkg::BIT_COUNT_DONE]) |->
    $past(lvl.count_zero && (generic_slave_dma_mode || master_dma_mode)))
    else $error("count flag set outside dma modes");

  a_xfer_irq: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(reason_r[drq_pkg::BIT_XFER_IRQ]) |-> $past(cnt_now && irq_now))
    else $error("transfer and interrupt flag set early");

  a_wr_empty: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(lvl.wr_fifo_empty) |=> reason_r[drq_pkg::BIT_WR_EMPTY])
    else $error("write fifo empty flag not set");

  a_rsv_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    ((reason_r & ~drq_pkg::REASON_MASK) == 16'h0000) &&
    ((endpoint_r & ~drq_pkg::EP_MASK) == 8'h00))
    else $error("reserved bits not zero");

  a_rd_data: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && hit_ep) |=> (hrdata == {24'h000000, $past(endpoint_r)}))
    else $error("endpoint read data wrong");

  a_ep_fields: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ep |=> (dma_endpoint_index == $past(hwdata[3:1])) &&
    (dma_direction_select == $past(hwdata[0])))
    else $error("endpoint fields not updated");

  a_tf_code: assert property (@(posedge hclk) disable iff (!hresetn)
    tf_out.strobe |-> !tf_out.cs1 && tf_out.cs0 && (tf_out.da == 3'h7) &&
    (tf_out.data == drive_addr_r))
    else $error("drive address strobe wrong select code");

  // a flag raised in the cycle of its own clear must survive
  a_set_wins: assert property (@(posedge hclk) disable iff (!hresetn)
    ((set_vec & drq_pkg::REASON_MASK) != 16'h0000) |=>
    ((reason_r & $past(set_vec & drq_pkg::REASON_MASK)) == $past(set_vec & drq_pkg::REASON_MASK)))
    else $error("reason flag lost against a clear");

  a_w1c_any: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_rsn |=>
    ((reason_r & $past(hwdata[15:0] & ~set_vec)) == 16'h0000))
    else $error("reason flags not cleared by writing ones");

  a_flag_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_rsn |=>
    ((reason_r & $past(reason_r)) == $past(reason_r)))
    else $error("reason flag dropped without a clear");

  a_drv_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_drv |=>
    (drive_addr_r == $past(hwdata[7:0])))
    else $error("drive address register not written");

  a_drv_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_drv |=>
    $stable(drive_addr_r))
    else $error("drive address register changed without a write");

  a_ena_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ena |=>
    (enable_r == $past(hwdata[15:0] & drq_pkg::REASON_MASK)))
    else $error("enable register not written");

  a_ena_rsv: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |->
    ((enable_r & ~drq_pkg::REASON_MASK) == 16'h0000))
    else $error("reserved enable bits not zero");

  a_ep_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_ep |=>
    $stable(endpoint_r))
    else $error("endpoint register changed without a write");

  // packet mode: register reserved, nothing leaves towards the drive
  a_drv_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    !ata_mode |->
    (drive_address == 8'h00))
    else $error("drive address shown in packet mode");

  a_tf_atapi: assert property (@(posedge hclk) disable iff (!hresetn)
    (evt.tf_push && !ata_mode) |=>
    !tf_out.strobe)
    else $error("drive address strobe in packet mode");

  a_tf_push: assert property (@(posedge hclk) disable iff (!hresetn)
    (evt.tf_push && ata_mode) |=>
    tf_out.strobe)
    else $error("drive address strobe missing");

  a_tf_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    !tf_out.strobe |->
    (tf_out.cs1 && tf_out.cs0 && (tf_out.da == drq_pkg::TF_DA_IDLE)))
    else $error("drive select lines not idle");

  a_busy_set: assert property (@(posedge hclk) disable iff (!hresetn)
    busy_end |=>
    reason_r[drq_pkg::BIT_BUSY_DONE])
    else $error("busy poll flag not set");

  a_busy_only: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(reason_r[drq_pkg::BIT_BUSY_DONE]) |->
    $past(busy_end))
    else $error("busy poll flag set while busy");

  a_tfrb_set: assert property (@(posedge hclk) disable iff (!hresetn)
    evt.tf_readback_done |=>
    reason_r[drq_pkg::BIT_TF_READBACK])
    else $error("readback flag not set");

  a_count_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (cnt_rise && dma_mode) |=>
    reason_r[drq_pkg::BIT_COUNT_DONE])
    else $error("count flag not set");

  a_refresh: assert property (@(posedge hclk) disable iff (!hresetn)
    (refresh && lvl.drive_intrq) |=>
    reason_r[drq_pkg::BIT_DRIVE_IRQ])
    else $error("drive interrupt flag not refreshed");

  a_wr_full: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(lvl.wr_fifo_full) |=>
    reason_r[drq_pkg::BIT_WR_FULL])
    else $error("write fifo full flag not set");

  a_rd_empty: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(lvl.rd_fifo_empty) |=>
    reason_r[drq_pkg::BIT_RD_EMPTY])
    else $error("read fifo empty flag not set");

  a_rd_avail: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(lvl.rd_fifo_avail) |=>
    reason_r[drq_pkg::BIT_RD_AVAIL])
    else $error("read data flag not set");

  // interrupt seen first, count reaching zero second
  a_xfer_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (cnt_rise && irq_seen_r && !cnt_seen_r) |=>
    reason_r[drq_pkg::BIT_XFER_IRQ])
    else $error("transfer and interrupt flag not set");

  a_irq_enable: assert property (@(posedge hclk) disable iff (!hresetn)
    (reason_r[drq_pkg::BIT_DRIVE_IRQ] && enable_r[drq_pkg::BIT_DRIVE_IRQ]) |->
    dma_irq)
    else $error("enabled flag does not raise the interrupt");

  a_rd_reason: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && hit_rsn) |=>
    (hrdata == {16'h0000, $past(reason_r)}))
    else $error("reason read data wrong");

  a_rd_enable: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && hit_ena) |=>
    (hrdata == {16'h0000, $past(enable_r)}))
    else $error("enable read data wrong");

  a_rd_drv: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && hit_drv) |=>
    (hrdata == {24'h000000, $past(drive_addr_r)}))
    else $error("drive address read data wrong");

endmodule : drq_regs

// >>> verification/drq_drive_model.sv
`timescale 1ns/10ps
module drq_drive_model
(
  // clock
  input  wire logic                hclk,
  // requests from the bench
  input  wire drq_pkg::drq_level_s lvl_req,
  input  wire drq_pkg::drq_pulse_s evt_req,
  // towards the register block
  output drq_pkg::drq_level_s      lvl,
  output drq_pkg::drq_pulse_s      evt
);
  // registered so every change lands just after an edge, like real engine logic
  always_ff @(posedge hclk)
  begin
    // a fifo never reports full and empty together
    lvl <= drq_pkg::drq_level_s'(lvl_req & ~{2'b00, lvl_req.wr_fifo_empty, 1'b0,
                                             lvl_req.rd_fifo_empty, 3'b000});
    evt <= evt_req;
  end
endmodule : drq_drive_model

// >>> verification/drq_regs_tb.sv
`timescale 1ns/10ps
module drq_regs_tb;
  logic                hclk;
  logic                hresetn;
  logic                hsel;
  logic [31:0]         haddr;
  logic [1:0]          htrans;
  logic                hwrite;
  logic [2:0]          hsize;
  logic [31:0]         hwdata;
  logic                hreadyout;
  logic [1:0]          hresp;
  logic [31:0]         hrdata;
  drq_pkg::drq_level_s lvl;
  drq_pkg::drq_level_s lvl_req;
  drq_pkg::drq_pulse_s evt;
  drq_pkg::drq_pulse_s evt_req;
  logic                ata_mode;
  logic                generic_slave_dma_mode;
  logic                master_dma_mode;
  logic                dma_irq;
  logic [2:0]          dma_endpoint_index;
  logic                dma_direction_select;
  logic [7:0]          drive_address;
  drq_pkg::drq_tf_s    tf_out;
  int                  failures;
  int                  n_checks;
  int                  seed;
  logic [31:0]         d;

  drq_regs i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .lvl(lvl), .evt(evt),
    .ata_mode(ata_mode), .generic_slave_dma_mode(generic_slave_dma_mode),
    .master_dma_mode(master_dma_mode), .dma_irq(dma_irq),
    .dma_endpoint_index(dma_endpoint_index), .dma_direction_select(dma_direction_select),
    .drive_address(drive_address), .tf_out(tf_out));

  drq_drive_model i_model (.hclk(hclk), .lvl_req(lvl_req), .evt_req(evt_req), .lvl(lvl),
    .evt(evt));

  task automatic give_verdict;
    if (failures == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // the master waits on hready; only the watchdog ends a stuck wait
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] v,
                     output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= drq_pkg::HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    chk({30'h0, hresp}, {30'h0, drq_pkg::HRESP_OKAY});
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    logic [31:0] q;
    bus(1'b1, a, v, q);
  endtask : wr

  task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rdchk

  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask : idle

  task automatic setlvl(input logic [7:0] v);
    lvl_req <= drq_pkg::drq_level_s'(v);
  endtask : setlvl

  task automatic pulse(input logic [3:0] p);
    evt_req <= drq_pkg::drq_pulse_s'(p);
    @(posedge hclk);
    evt_req <= drq_pkg::drq_pulse_s'(4'h0);
  endtask : pulse

  task automatic clr;
    wr(drq_pkg::BA_REASON, 32'hffff_ffff);
  endtask : clr

  task automatic irqchk(input logic e);
    #1;
    chk({31'h0, dma_irq}, {31'h0, e});
    @(posedge hclk);
  endtask : irqchk

  task automatic tfwait(input logic e, input logic [7:0] v);
    logic seen;
    seen = 1'b0;
    repeat (4)
    begin
      @(posedge hclk);
      #1;
      if (tf_out.strobe === 1'b1 && !seen)
      begin
        seen = 1'b1;
        chk({17'h0, tf_out}, {18'h0, 1'b1, drq_pkg::TF_CS1_SEL, drq_pkg::TF_CS0_SEL,
            drq_pkg::TF_DA_SEL, v});
      end
    end
    chk({31'h0, seen}, {31'h0, e});
    @(posedge hclk);
  endtask : tfwait

  // reason flag expected from one rising engine level
  function automatic logic [31:0] flag_of(input int i);
    case (i)
      7: flag_of = 32'h200;
      6: flag_of = 32'h80;
      5: flag_of = 32'h40;
      4: flag_of = 32'h20;
      3: flag_of = 32'h10;
      default: flag_of = 32'h100;
    endcase
  endfunction : flag_of

  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  initial
  begin
    repeat (20000) @(posedge hclk);
    failures++;
    give_verdict();
  end

  initial
  begin
    failures = 0;
    n_checks = 0;
    seed = 95;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    lvl_req = drq_pkg::drq_level_s'(8'h00);
    evt_req = drq_pkg::drq_pulse_s'(4'h0);
    ata_mode = 1'b0;
    generic_slave_dma_mode = 1'b0;
    master_dma_mode = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(drq_pkg::BA_DRIVE_ADDR, 32'h0);
    rdchk(drq_pkg::BA_REASON, 32'h0);
    rdchk(drq_pkg::BA_ENABLE, 32'h0);
    rdchk(drq_pkg::BA_ENDPOINT, 32'h0);
    for (int k = 0; k < 8; k++)
    begin
      d = $random(seed);
      ata_mode <= d[31];
      wr(drq_pkg::BA_DRIVE_ADDR, d);
      wr(drq_pkg::BA_ENABLE, d);
      wr(drq_pkg::BA_ENDPOINT, d);
      wr(32'h0000_0100, d);
      #1;
      chk({29'h0, dma_endpoint_index}, {29'h0, d[3:1]});
      chk({31'h0, dma_direction_select}, {31'h0, d[0]});
      chk({24'h0, drive_address}, d[31] ? {24'h0, d[7:0]} : 32'h0);
      @(posedge hclk);
      rdchk(drq_pkg::BA_DRIVE_ADDR, d & 32'hff);
      rdchk(drq_pkg::BA_ENABLE, d & 32'h3fe);
      rdchk(drq_pkg::BA_ENDPOINT, d & 32'h0f);
      rdchk(32'h0000_0100, 32'h0);
    end
    master_dma_mode <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      if (i == 1 || i == 2)
        continue;
      pulse(4'h8);
      setlvl(8'h01 << i);
      idle(4);
      rdchk(drq_pkg::BA_REASON, flag_of(i));
      setlvl(8'h00);
      clr;
      rdchk(drq_pkg::BA_REASON, 32'h0);
    end
    master_dma_mode <= 1'b0;
    pulse(4'h8);
    setlvl(8'h80);
    idle(2);
    setlvl(8'h81);
    idle(4);
    rdchk(drq_pkg::BA_REASON, 32'h202);
    setlvl(8'h00);
    pulse(4'h8);
    clr;
    generic_slave_dma_mode <= 1'b1;
    setlvl(8'h01);
    idle(4);
    rdchk(drq_pkg::BA_REASON, 32'h100);
    setlvl(8'h06);
    idle(3);
    setlvl(8'h00);
    clr;
    rdchk(drq_pkg::BA_REASON, 32'h8);
    clr;
    pulse(4'h2);
    idle(3);
    rdchk(drq_pkg::BA_REASON, 32'h4);
    setlvl(8'h08);
    idle(3);
    clr;
    rdchk(drq_pkg::BA_REASON, 32'h0);
    pulse(4'h4);
    idle(3);
    rdchk(drq_pkg::BA_REASON, 32'h10);
    wr(drq_pkg::BA_REASON, 32'h0);
    rdchk(drq_pkg::BA_REASON, 32'h10);
    wr(drq_pkg::BA_ENABLE, 32'h10);
    irqchk(1'b1);
    wr(drq_pkg::BA_ENABLE, 32'h3ee);
    irqchk(1'b0);
    wr(drq_pkg::BA_ENABLE, 32'h10);
    clr;
    irqchk(1'b0);
    wr(drq_pkg::BA_DRIVE_ADDR, 32'h5a);
    ata_mode <= 1'b1;
    pulse(4'h1);
    tfwait(1'b1, 8'h5a);
    ata_mode <= 1'b0;
    pulse(4'h1);
    tfwait(1'b0, 8'h5a);
    wr(drq_pkg::BA_ENABLE, 32'h3fe);
    wr(drq_pkg::BA_ENDPOINT, 32'hf);
    setlvl(8'h00);
    idle(3);
    hresetn <= 1'b0;
    idle(2);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(drq_pkg::BA_ENABLE, 32'h0);
    rdchk(drq_pkg::BA_ENDPOINT, 32'h0);
    rdchk(drq_pkg::BA_DRIVE_ADDR, 32'h0);
    give_verdict();
  end
endmodule : drq_regs_tb
